// *** shared/hdcb_pkg.sv ***
package hdcb_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 8;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_BUS_CURRENT = 8'h0F;
    localparam logic [7:0] IDX_POWER_DELAY = 8'h10;
    localparam logic [7:0] IDX_LANG_HIGH = 8'h11;
    localparam logic [7:0] IDX_LANG_LOW = 8'h12;
    localparam logic [7:0] IDX_MAKER_LEN = 8'h13;
    localparam logic [7:0] IDX_PRODUCT_LEN = 8'h14;
    localparam logic [7:0] IDX_SERIAL_LEN = 8'h15;
    localparam logic [7:0] IDX_MAKER_TEXT = 8'h16;
    localparam logic [7:0] IDX_PRODUCT_TEXT = 8'h54;
    localparam logic [7:0] IDX_SERIAL_TEXT = 8'h92;
    localparam logic [7:0] IDX_LAST = 8'hCF;
    localparam logic [7:0] IDX_STATUS = 8'hE0;
    localparam int STORE_DEPTH = 193;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] MAX_CHARS = 5'h1F;
    localparam int TEXT_BYTES = 62;
    localparam int CURRENT_UNIT_MA = 2;
    localparam int DELAY_UNIT_MS = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {SEL_MAKER, SEL_PRODUCT, SEL_SERIAL, SEL_LANG} hdcb_sel_t;

    typedef struct packed {
        logic valid;
        hdcb_sel_t sel;
        logic [4:0] idx;
    } hdcb_req_t;

    typedef struct packed {
        logic valid;
        logic beyond;
        logic last;
        logic [15:0] ch;
    } hdcb_ans_t;
endpackage

// *** hw/hdcb_bank.sv ***
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// How it works
// RL1: current budget byte counts 2 mA units drawn from upstream VBUS.
// RL2: software makes the budget cover hub silicon plus VBUS-powered board.
// RL3: software leaves embedded compound peripherals out of the budget.
// RL4: power-on delay byte counts 2 ms units until port power good.
// RL5: programmed power-on delay stays readable by host software.
// RL6: language code upper byte comes from the high register.
// RL7: language code lower byte comes from the low register.
// RL8: software keeps each text length at 31 characters or fewer.
// RL9: each text region holds at most 31 UTF-16LE characters, 62 bytes.
// RL10: character low byte at lower index, high byte next, ascending.
// RL11: maker text bytes sit at indexes 16h through 53h.
// RL12: product text bytes sit at indexes 54h through 91h.
// RL13: serial text bytes sit at indexes 92h through CFh.
// RL14: descriptor fetch returns only length characters from region start.
module hdcb_bank
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [hdcb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hdcb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire hdcb_pkg::hdcb_req_t desc_req,
    output hdcb_pkg::hdcb_ans_t desc_ans,
    output logic [9:0] bus_current_ma,
    output logic [8:0] power_good_delay_ms,
    output logic [15:0] language_code
);
    import hdcb_pkg::*;

    logic [7:0] mem_reg [0:STORE_DEPTH-1];
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane_reg;

    // store offset (index minus 0Fh) for a byte address, 100h for the status index, or all ones when unmapped
    function automatic logic [8:0] decode(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-3:0] idx;
        idx = a[ADDR_W-1:2];
        decode = 9'h1FF;
        if (a[1:0] == 2'h0 && idx >= (ADDR_W-2)'(IDX_BUS_CURRENT) && idx <= (ADDR_W-2)'(IDX_LAST))
        begin
            decode = {1'b0, 8'(idx[7:0] - IDX_BUS_CURRENT)};
        end
        else if (a[1:0] == 2'h0 && idx == (ADDR_W-2)'(IDX_STATUS))
        begin
            decode = 9'h100;
        end
    endfunction

    function automatic logic [7:0] text_base(input hdcb_sel_t s);
        case (s)
            SEL_MAKER: text_base = IDX_MAKER_TEXT - IDX_BUS_CURRENT; // [RL11]
            SEL_PRODUCT: text_base = IDX_PRODUCT_TEXT - IDX_BUS_CURRENT; // [RL12]
            default: text_base = IDX_SERIAL_TEXT - IDX_BUS_CURRENT; // [RL13]
        endcase
    endfunction

    // write channel, plus read address decode and read handshake
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_reg || aw_fire;
    wire w_have = w_hold_reg || w_fire;
    wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire [8:0] wr_dec = decode(aw_addr_reg);
    wire wr_store = !wr_dec[8] && w_lane_reg;
    wire [8:0] rd_dec = decode(s_axi_araddr);
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire rvalid_next = (s_axi_rvalid && !s_axi_rready) || ar_fire;
    wire aw_hold_next = aw_have && !do_write;
    wire w_hold_next = w_have && !do_write;

    // text lengths above the region size are flagged and clamped
    logic [2:0] len_over;
    logic [4:0] len_eff [0:2];
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_len
            wire [7:0] len = mem_reg[8'(IDX_MAKER_LEN - IDX_BUS_CURRENT) + 8'(g)];
            assign len_over[g] = len > 8'(MAX_CHARS);
            assign len_eff[g] = len_over[g] ? MAX_CHARS : len[4:0]; // [RL9]
        end
    endgenerate

    wire [7:0] status_byte = {5'h00, len_over};
    wire [7:0] rd_byte = rd_dec[8] ? status_byte : mem_reg[rd_dec[7:0]]; // [RL5]

    // descriptor fetch
    wire is_lang = desc_req.sel == SEL_LANG;
    wire [4:0] req_count = is_lang ? 5'h01 : len_eff[desc_req.sel];
    wire req_beyond = desc_req.idx >= req_count; // [RL14]
    // one bit wider so that index 31 cannot wrap onto a zero length
    wire req_last = ({1'b0, desc_req.idx} + 6'h01) == {1'b0, req_count};
    wire [7:0] char_lo = text_base(desc_req.sel) + {2'h0, desc_req.idx, 1'b0}; // [RL10]
    wire [15:0] text_char = {mem_reg[char_lo + 8'h01], mem_reg[char_lo]}; // [RL10]
    wire [15:0] lang_char = {mem_reg[IDX_LANG_HIGH - IDX_BUS_CURRENT],
                             mem_reg[IDX_LANG_LOW - IDX_BUS_CURRENT]}; // [RL6] [RL7]
    wire [15:0] req_char = req_beyond ? 16'h0000 : (is_lang ? lang_char : text_char);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_byte_reg <= REG_RESET;
            w_lane_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            s_axi_awready <= !aw_hold_next;
            s_axi_wready <= !w_hold_next;
            if (aw_fire)
            begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_fire)
            begin
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_dec == 9'h1FF) ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte store; status index is read only
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < STORE_DEPTH; i++)
        begin
            if (!aresetn)
            begin
                mem_reg[i] <= REG_RESET;
            end
            else if (do_write && wr_store && wr_dec[7:0] == 8'(i))
            begin
                mem_reg[i] <= w_byte_reg;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_rvalid <= rvalid_next;
            s_axi_arready <= !rvalid_next;
            if (ar_fire)
            begin
                s_axi_rdata <= (rd_dec == 9'h1FF) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
                s_axi_rresp <= (rd_dec == 9'h1FF) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            desc_ans <= '0;
            bus_current_ma <= '0;
            power_good_delay_ms <= '0;
            language_code <= '0;
        end
        else
        begin
            desc_ans.valid <= desc_req.valid;
            desc_ans.beyond <= req_beyond;
            desc_ans.last <= req_last;
            desc_ans.ch <= req_char;
            bus_current_ma <= 10'(mem_reg[0]) * 10'(CURRENT_UNIT_MA); // [RL1]
            power_good_delay_ms <= 9'(mem_reg[1]) * 9'(DELAY_UNIT_MS); // [RL4]
            language_code <= lang_char; // [RL6] [RL7]
        end
    end

    property p_rl1;
        @(posedge aclk) disable iff (!aresetn)
        $stable(mem_reg[0]) |=> bus_current_ma == {1'b0, $past(mem_reg[0]), 1'b0};
    endproperty
    a_rl1: assert property (p_rl1) else $error("current budget not in 2 mA units"); // [RL1]

    property p_rl4;
        @(posedge aclk) disable iff (!aresetn)
        ##1 power_good_delay_ms == {$past(mem_reg[1]), 1'b0};
    endproperty
    a_rl4: assert property (p_rl4) else $error("power delay not in 2 ms units"); // [RL4]

    property p_rl5;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && s_axi_araddr == ADDR_W'({IDX_POWER_DELAY, 2'h0})
        |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata == {24'h0, $past(mem_reg[1])};
    endproperty
    a_rl5: assert property (p_rl5) else $error("power delay read wrong"); // [RL5]

    property p_rl6;
        @(posedge aclk) disable iff (!aresetn)
        ##1 language_code[15:8] == $past(mem_reg[2]);
    endproperty
    a_rl6: assert property (p_rl6) else $error("language upper byte wrong"); // [RL6]

    property p_rl7;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_LANG && desc_req.idx == 5'h00
        |=> desc_ans.ch[7:0] == $past(mem_reg[3]) && language_code[7:0] == $past(mem_reg[3]);
    endproperty
    a_rl7: assert property (p_rl7) else $error("language lower byte wrong"); // [RL7]

    property p_rl9;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.idx == MAX_CHARS |=> desc_ans.valid && desc_ans.beyond;
    endproperty
    a_rl9: assert property (p_rl9) else $error("character past region returned"); // [RL9]

    property p_rl10;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && !req_beyond && !is_lang
        |=> desc_ans.ch == {$past(mem_reg[char_lo + 8'h01]), $past(mem_reg[char_lo])};
    endproperty
    a_rl10: assert property (p_rl10) else $error("character byte order wrong"); // [RL10]

    property p_rl11;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_MAKER && desc_req.idx == 5'h00 && !req_beyond
        |=> desc_ans.ch == {$past(mem_reg[8'h08]), $past(mem_reg[8'h07])};
    endproperty
    a_rl11: assert property (p_rl11) else $error("maker text misplaced"); // [RL11]

    property p_rl12;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_PRODUCT && desc_req.idx == 5'h00 && !req_beyond
        |=> desc_ans.ch == {$past(mem_reg[8'h46]), $past(mem_reg[8'h45])};
    endproperty
    a_rl12: assert property (p_rl12) else $error("product text misplaced"); // [RL12]

    property p_rl13;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_SERIAL && desc_req.idx == 5'h1E && !req_beyond
        |=> desc_ans.ch == {$past(mem_reg[8'hC0]), $past(mem_reg[8'hBF])};
    endproperty
    a_rl13: assert property (p_rl13) else $error("serial text misplaced"); // [RL13]

    property p_rl14;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_MAKER
        |=> desc_ans.beyond == ($past(desc_req.idx) >= $past(len_eff[0])) && desc_ans.valid;
    endproperty
    a_rl14: assert property (p_rl14) else $error("maker length not honoured"); // [RL14]

    property p_rl9_clamp;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.sel == SEL_PRODUCT && desc_req.idx == 5'h1E
        && mem_reg[IDX_PRODUCT_LEN - IDX_BUS_CURRENT] > 8'(MAX_CHARS)
        |=> desc_ans.valid && !desc_ans.beyond && desc_ans.last;
    endproperty
    a_rl9_clamp: assert property (p_rl9_clamp) else $error("length not clamped"); // [RL9]

    property p_rl14_past;
        @(posedge aclk) disable iff (!aresetn)
        desc_req.valid && desc_req.idx == MAX_CHARS
        |=> desc_ans.valid && !desc_ans.last && desc_ans.ch == 16'h0000;
    endproperty
    a_rl14_past: assert property (p_rl14_past) else $error("past char not blank"); // [RL14]

    property p_rl11_edge;
        @(posedge aclk) disable iff (!aresetn)
        do_write && wr_store && aw_addr_reg == ADDR_W'({IDX_PRODUCT_TEXT - 8'h01, 2'h0})
        |=> mem_reg[IDX_PRODUCT_TEXT - IDX_BUS_CURRENT - 8'h01] == $past(w_byte_reg);
    endproperty
    a_rl11_edge: assert property (p_rl11_edge) else $error("maker end byte misplaced"); // [RL11]

    property p_wr_answer;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |=> ##1 s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer not in two cycles");

    property p_wr_refused;
        @(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr_reg[1:0] != 2'h0
        |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    a_wr_refused: assert property (p_wr_refused) else $error("misaligned write accepted");

    property p_lane_off;
        @(posedge aclk) disable iff (!aresetn)
        do_write && !w_lane_reg && aw_addr_reg == ADDR_W'({IDX_BUS_CURRENT, 2'h0})
        |=> mem_reg[0] == $past(mem_reg[0]) && s_axi_bresp == RESP_OKAY;
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("write with lane off stored");

    property p_rd_unmapped;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_dec == 9'h1FF
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");

    property p_status;
        @(posedge aclk) disable iff (!aresetn)
        ar_fire && s_axi_araddr == ADDR_W'({IDX_STATUS, 2'h0})
        |=> s_axi_rdata[1] == ($past(mem_reg[IDX_PRODUCT_LEN - IDX_BUS_CURRENT]) > 8'(MAX_CHARS));
    endproperty
    a_status: assert property (p_status) else $error("length flag wrong");
endmodule

// *** verification/hdcb_bank_tb.sv ***
`timescale 1ns/1ps
module hdcb_bank_tb;
    import hdcb_pkg::*;
    typedef struct packed {logic [7:0] idx; logic [7:0] val;} hdcb_row_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] strb;
    logic [1:0] bresp, rresp, rsp;
    logic [9:0] cur_ma;
    logic [8:0] dly_ms;
    logic [15:0] lang;
    hdcb_req_t desc_req;
    hdcb_ans_t desc_ans, ans;
    int error_cnt, compares;
    hdcb_row_t rows [16] = '{'{8'h0F, 8'hA5}, '{8'h10, 8'hFF}, '{8'h11, 8'h04},
        '{8'h12, 8'h09}, '{8'h13, 8'h02}, '{8'h14, 8'h1F}, '{8'h15, 8'h1F},
        '{8'h16, 8'h41}, '{8'h17, 8'h00}, '{8'h18, 8'h42}, '{8'h19, 8'h01},
        '{8'h53, 8'h7E}, '{8'h54, 8'hC3}, '{8'h91, 8'h5A}, '{8'h92, 8'h33}, '{8'hCF, 8'hE1}};

    hdcb_bank i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .desc_req(desc_req), .desc_ans(desc_ans),
        .bus_current_ma(cur_ma), .power_good_delay_ms(dly_ms), .language_code(lang));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        if (n >= 50)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic bus_rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask

    task automatic fetch(input hdcb_sel_t s, input logic [4:0] i);
        @(posedge aclk);
        desc_req <= '{1'b1, s, i};
        @(posedge aclk);
        desc_req.valid <= 1'b0;
        #1 ans = desc_ans;
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        strb = 4'h1;
        desc_req = '0;
        error_cnt = 0;
        compares = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        bus_rd({2'h0, IDX_SERIAL_TEXT, 2'h0});
        chk(rd, 32'h0);
        foreach (rows[k])
        begin
            bus_wr({2'h0, rows[k].idx, 2'h0}, rows[k].val);
            chk(rsp, RESP_OKAY);
            bus_rd({2'h0, rows[k].idx, 2'h0});
            chk(rd, {24'h0, rows[k].val});
        end
        chk(cur_ma, 10'(8'hA5) * CURRENT_UNIT_MA);
        chk(dly_ms, 9'(8'hFF) * DELAY_UNIT_MS);
        chk(lang, 16'h0409);
        fetch(SEL_MAKER, 5'h00);
        chk(ans, {1'b1, 2'b00, 16'h0041});
        fetch(SEL_MAKER, 5'h01);
        chk(ans, {1'b1, 2'b01, 16'h0142});
        fetch(SEL_MAKER, 5'h02);
        chk(ans, {1'b1, 2'b10, 16'h0000});
        fetch(SEL_PRODUCT, 5'h00);
        chk(ans, {1'b1, 2'b00, 16'h00C3});
        fetch(SEL_PRODUCT, 5'h1E);
        chk(ans, {1'b1, 2'b01, 16'h5A00});
        fetch(SEL_SERIAL, 5'h00);
        chk(ans, {1'b1, 2'b00, 16'h0033});
        fetch(SEL_SERIAL, 5'h1E);
        chk(ans, {1'b1, 2'b01, 16'hE100});
        fetch(SEL_SERIAL, 5'h1F);
        chk(ans, {1'b1, 2'b10, 16'h0000});
        fetch(SEL_LANG, 5'h00);
        chk(ans, {1'b1, 2'b01, 16'h0409});
        bus_rd({2'h0, 8'hD0, 2'h0});
        chk({rsp, rd}, {RESP_SLVERR, 32'h0});
        bus_wr(12'h03D, 8'h11);
        chk(rsp, RESP_SLVERR);
        strb <= 4'h0;
        bus_wr({2'h0, IDX_BUS_CURRENT, 2'h0}, 8'h22);
        strb <= 4'h1;
        chk(rsp, RESP_OKAY);
        bus_rd({2'h0, IDX_BUS_CURRENT, 2'h0});
        chk(rd, 32'hA5);
        bus_wr({2'h0, IDX_PRODUCT_LEN, 2'h0}, 8'h25);
        bus_rd({2'h0, IDX_STATUS, 2'h0});
        chk(rd, 32'h2);
        fetch(SEL_PRODUCT, 5'h1E);
        chk(ans, {1'b1, 2'b01, 16'h5A00});
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1 chk({cur_ma, dly_ms, lang}, 35'h0);
        @(posedge aclk);
        bus_rd({2'h0, IDX_MAKER_TEXT, 2'h0});
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule
